// *** rtl/cms_pkg.sv ***
package cms_pkg;

   // ****************************************************************
   // Strap indices and sizes
   // ****************************************************************
   localparam int STRAP_COUNT = 6;
   localparam int STRAP_PRIMARY = 0;
   localparam int STRAP_SECONDARY = 1;
   localparam int STRAP_SWING = 2;
   localparam int STRAP_EDGE = 3;
   localparam int STRAP_CAL = 4;
   localparam int STRAP_RANGE = 5;
   localparam int SYNC_STAGES = 2;
   localparam logic [1:0] SETTLE_CYCLES = 2'h3;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic RST_SERIAL_MODE = 1'h0;
   localparam logic RST_REDUCED_RANGE = 1'h0;
   localparam logic RST_REDUCED_SWING = 1'h0;
   localparam logic RST_EDGE_POS = 1'h1;
   localparam logic RST_DDR = 1'h0;
   localparam logic RST_CAL_LONG = 1'h0;
   localparam logic RST_DUAL_EDGE = 1'h0;
   localparam logic IDLE_SERIAL_CLOCK = 1'h0;
   localparam logic IDLE_SERIAL_DATA = 1'h0;
   localparam logic IDLE_CHIP_SELECT = 1'h1;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [1:0] {
      CMS_LOW = 2'h0,
      CMS_HIGH = 2'h1,
      CMS_FLOAT = 2'h3
   } cms_level_t;

   typedef enum logic {
      CMS_MODE_PIN = 1'h0,
      CMS_MODE_SERIAL = 1'h1
   } cms_mode_t;

   typedef struct packed {
      logic [STRAP_COUNT-1:0] high;
      logic [STRAP_COUNT-1:0] low;
   } cms_sense_t;

   typedef struct packed {
      logic reduced_range;
      logic reduced_swing;
      logic output_edge_select;
      logic ddr_enable;
      logic calibration_delay_select;
      logic dual_edge_sampling;
   } cms_cfg_t;

   typedef struct packed {
      logic serial_clock;
      logic serial_data_in;
      logic serial_chip_select;
   } cms_serial_t;

   localparam cms_cfg_t CFG_RESET = '{
      reduced_range: RST_REDUCED_RANGE,
      reduced_swing: RST_REDUCED_SWING,
      output_edge_select: RST_EDGE_POS,
      ddr_enable: RST_DDR,
      calibration_delay_select: RST_CAL_LONG,
      dual_edge_sampling: RST_DUAL_EDGE
   };

   localparam cms_serial_t SERIAL_IDLE = '{
      serial_clock: IDLE_SERIAL_CLOCK,
      serial_data_in: IDLE_SERIAL_DATA,
      serial_chip_select: IDLE_CHIP_SELECT
   };

endpackage

// *** rtl/cms_strap_decode.sv ***
// Overview of operation
// - Primary select high forces pin-programmed mode.
// - Primary floating, secondary float/high: range strap float selects serial.
// - Primary low, secondary float/high: serial mode.
// - Pin mode: straps set all except edge select when edge floats, serial ignored.
// - Range strap low reduced, high normal.
// - Swing strap low reduced, high normal.
// - Edge strap high positive, low negative edge.
// - Edge strap floating selects double data rate.
// - Calibration strap low short, high long delay.
// - Calibration strap floating: short delay, dual-edge.
// - Serial mode: swing/edge/cal pins become serial.
`timescale 1ns/1ps
`default_nettype none

module cms_strap_decode (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire cms_pkg::cms_sense_t strap_sense,
   output var logic serial_mode,
   output var cms_pkg::cms_cfg_t pin_cfg,
   output var cms_pkg::cms_serial_t serial_port
);

   // ****************************************************************
   // Resolution helper
   // ****************************************************************

   // A pad that senses both thresholds at once is treated as floating.
   function automatic cms_pkg::cms_level_t resolve(input logic hi, input logic lo);
      cms_pkg::cms_level_t lvl;
      lvl = cms_pkg::CMS_FLOAT;
      if (hi && !lo) begin
         lvl = cms_pkg::CMS_HIGH;
      end else if (lo && !hi) begin
         lvl = cms_pkg::CMS_LOW;
      end
      return lvl;
   endfunction

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   logic [cms_pkg::STRAP_COUNT-1:0] high_meta_reg;
   logic [cms_pkg::STRAP_COUNT-1:0] high_sync_reg;
   logic [cms_pkg::STRAP_COUNT-1:0] low_meta_reg;
   logic [cms_pkg::STRAP_COUNT-1:0] low_sync_reg;
   cms_pkg::cms_level_t level [cms_pkg::STRAP_COUNT];

   genvar gi;
   generate
      for (gi = 0; gi < cms_pkg::STRAP_COUNT; gi++) begin : g_strap
         always_ff @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
               high_meta_reg[gi] <= 1'h0;
               high_sync_reg[gi] <= 1'h0;
               low_meta_reg[gi] <= 1'h0;
               low_sync_reg[gi] <= 1'h0;
            end else begin
               high_meta_reg[gi] <= strap_sense.high[gi];
               high_sync_reg[gi] <= high_meta_reg[gi];
               low_meta_reg[gi] <= strap_sense.low[gi];
               low_sync_reg[gi] <= low_meta_reg[gi];
            end
         end

         // Each strap is reduced to one of three states.
         always_comb begin
            level[gi] = resolve(high_sync_reg[gi], low_sync_reg[gi]);
         end
      end
   endgenerate

   // ****************************************************************
   // Synchroniser fill
   // ****************************************************************
   logic [cms_pkg::SYNC_STAGES-1:0] fill_reg;
   logic sync_full;

   // Cleared stages read as all floating, which would decode to serial mode with chip
   // select asserted, even with the primary select high; outputs keep their reset values
   // until both stages hold real pin samples.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         fill_reg <= {cms_pkg::SYNC_STAGES{1'h0}};
      end else begin
         fill_reg <= {fill_reg[cms_pkg::SYNC_STAGES-2:0], 1'h1};
      end
   end
   assign sync_full = fill_reg[cms_pkg::SYNC_STAGES-1];

   // ****************************************************************
   // Mode decode
   // ****************************************************************
   cms_pkg::cms_mode_t mode_next;
   logic secondary_ok;

   // A low secondary select keeps the serial interface shut.
   always_comb begin
      secondary_ok = (level[cms_pkg::STRAP_SECONDARY] != cms_pkg::CMS_LOW);
      mode_next = cms_pkg::CMS_MODE_PIN;
      case (level[cms_pkg::STRAP_PRIMARY])
         cms_pkg::CMS_HIGH: begin
            mode_next = cms_pkg::CMS_MODE_PIN;
         end
         cms_pkg::CMS_LOW: begin
            if (secondary_ok) begin
               mode_next = cms_pkg::CMS_MODE_SERIAL;
            end
         end
         default: begin
            if (secondary_ok && level[cms_pkg::STRAP_RANGE] == cms_pkg::CMS_FLOAT) begin
               mode_next = cms_pkg::CMS_MODE_SERIAL;
            end
         end
      endcase
   end

   // ****************************************************************
   // Setting decode
   // ****************************************************************
   cms_pkg::cms_cfg_t cfg_next;

   // In serial mode the settings hold their last values: strap-programmed, or the reset values if no pin mode came first.
   always_comb begin
      cfg_next = pin_cfg;
      if (mode_next == cms_pkg::CMS_MODE_PIN) begin
         cfg_next.reduced_range = (level[cms_pkg::STRAP_RANGE] == cms_pkg::CMS_LOW);
         // A floating swing strap is unused and keeps normal swing.
         cfg_next.reduced_swing = (level[cms_pkg::STRAP_SWING] == cms_pkg::CMS_LOW);
         case (level[cms_pkg::STRAP_EDGE])
            cms_pkg::CMS_HIGH: begin
               cfg_next.output_edge_select = 1'h1;
               cfg_next.ddr_enable = 1'h0;
            end
            cms_pkg::CMS_LOW: begin
               cfg_next.output_edge_select = 1'h0;
               cfg_next.ddr_enable = 1'h0;
            end
            default: begin
               // The edge choice is irrelevant when data leaves on both edges.
               cfg_next.output_edge_select = pin_cfg.output_edge_select;
               cfg_next.ddr_enable = 1'h1;
            end
         endcase
         case (level[cms_pkg::STRAP_CAL])
            cms_pkg::CMS_HIGH: begin
               cfg_next.calibration_delay_select = 1'h1;
               cfg_next.dual_edge_sampling = 1'h0;
            end
            cms_pkg::CMS_LOW: begin
               cfg_next.calibration_delay_select = 1'h0;
               cfg_next.dual_edge_sampling = 1'h0;
            end
            default: begin
               cfg_next.calibration_delay_select = 1'h0;
               cfg_next.dual_edge_sampling = 1'h1;
            end
         endcase
      end
   end

   // ****************************************************************
   // Serial pin routing
   // ****************************************************************
   cms_pkg::cms_serial_t serial_next;

   // Outside serial mode the port sits idle so that no access can land.
   always_comb begin
      serial_next = cms_pkg::SERIAL_IDLE;
      if (mode_next == cms_pkg::CMS_MODE_SERIAL) begin
         serial_next.serial_clock = high_sync_reg[cms_pkg::STRAP_SWING];
         serial_next.serial_data_in = high_sync_reg[cms_pkg::STRAP_EDGE];
         serial_next.serial_chip_select = high_sync_reg[cms_pkg::STRAP_CAL];
      end
   end

   // ****************************************************************
   // Output registers
   // ****************************************************************
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         serial_mode <= cms_pkg::RST_SERIAL_MODE;
      end else if (!sync_full) begin
         serial_mode <= cms_pkg::RST_SERIAL_MODE;
      end else begin
         serial_mode <= (mode_next == cms_pkg::CMS_MODE_SERIAL);
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pin_cfg <= cms_pkg::CFG_RESET;
      end else if (!sync_full) begin
         pin_cfg <= cms_pkg::CFG_RESET;
      end else begin
         pin_cfg <= cfg_next;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         serial_port <= cms_pkg::SERIAL_IDLE;
      end else if (!sync_full) begin
         serial_port <= cms_pkg::SERIAL_IDLE;
      end else begin
         serial_port <= serial_next;
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************

   // Counts edges since reset so that pin history three deep is valid.
   logic [1:0] settle_reg;
   logic settled;
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         settle_reg <= 2'h0;
      end else if (settle_reg != cms_pkg::SETTLE_CYCLES) begin
         settle_reg <= settle_reg + 2'h1;
      end
   end
   assign settled = (settle_reg == cms_pkg::SETTLE_CYCLES);

   logic [cms_pkg::STRAP_COUNT-1:0] pin_hi;
   logic [cms_pkg::STRAP_COUNT-1:0] pin_lo;
   logic [cms_pkg::STRAP_COUNT-1:0] pin_fl;
   assign pin_hi = strap_sense.high & ~strap_sense.low;
   assign pin_lo = strap_sense.low & ~strap_sense.high;
   assign pin_fl = ~(pin_hi | pin_lo);

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);

   AST_PRIMARY_HIGH_PIN_MODE: assert property (
      settled && $past(pin_hi[cms_pkg::STRAP_PRIMARY], 3) |-> !serial_mode)
      else $error("Primary select high did not give pin-programmed mode.");

   AST_RANGE_FLOAT_SERIAL: assert property (
      settled && $past(pin_fl[cms_pkg::STRAP_PRIMARY], 3)
      && !$past(pin_lo[cms_pkg::STRAP_SECONDARY], 3)
      |-> serial_mode == $past(pin_fl[cms_pkg::STRAP_RANGE], 3))
      else $error("Range strap did not decide the mode as expected.");

   AST_PRIMARY_LOW_SERIAL: assert property (
      settled && $past(pin_lo[cms_pkg::STRAP_PRIMARY], 3) |->
      serial_mode == !$past(pin_lo[cms_pkg::STRAP_SECONDARY], 3))
      else $error("Primary select low gave the wrong mode.");

   AST_PIN_MODE_SERIAL_IDLE: assert property (
      !serial_mode |-> serial_port == cms_pkg::SERIAL_IDLE)
      else $error("Serial port active in pin-programmed mode.");

   AST_SERIAL_CFG_HOLDS: assert property (
      serial_mode && $past(serial_mode) |-> $stable(pin_cfg))
      else $error("Settings changed while in serial mode.");

   AST_RANGE_DECODE: assert property (
      settled && !serial_mode && !$past(pin_fl[cms_pkg::STRAP_RANGE], 3) |->
      pin_cfg.reduced_range == $past(pin_lo[cms_pkg::STRAP_RANGE], 3))
      else $error("Range strap decoded wrongly.");

   AST_SWING_DECODE: assert property (
      settled && !serial_mode |->
      pin_cfg.reduced_swing == $past(pin_lo[cms_pkg::STRAP_SWING], 3))
      else $error("Swing strap decoded wrongly.");

   AST_EDGE_DECODE: assert property (
      settled && !serial_mode && !$past(pin_fl[cms_pkg::STRAP_EDGE], 3) |->
      !pin_cfg.ddr_enable
      && pin_cfg.output_edge_select == $past(pin_hi[cms_pkg::STRAP_EDGE], 3))
      else $error("Edge strap decoded wrongly.");

   AST_DDR_DECODE: assert property (
      settled && !serial_mode |->
      pin_cfg.ddr_enable == $past(pin_fl[cms_pkg::STRAP_EDGE], 3))
      else $error("Double data rate select decoded wrongly.");

   AST_CAL_DECODE: assert property (
      settled && !serial_mode |->
      pin_cfg.calibration_delay_select == $past(pin_hi[cms_pkg::STRAP_CAL], 3))
      else $error("Calibration delay decoded wrongly.");

   AST_DUAL_EDGE_DECODE: assert property (
      settled && !serial_mode |->
      pin_cfg.dual_edge_sampling == $past(pin_fl[cms_pkg::STRAP_CAL], 3))
      else $error("Dual-edge sampling decoded wrongly.");

   AST_SERIAL_ROUTING: assert property (
      settled && serial_mode |->
      serial_port.serial_clock == $past(strap_sense.high[cms_pkg::STRAP_SWING], 3)
      && serial_port.serial_data_in == $past(strap_sense.high[cms_pkg::STRAP_EDGE], 3)
      && serial_port.serial_chip_select == $past(strap_sense.high[cms_pkg::STRAP_CAL], 3))
      else $error("Serial pins not routed in serial mode.");

   AST_BOTH_SENSE_FLOATS: assert property (
      settled && !serial_mode && $past(strap_sense.high[cms_pkg::STRAP_CAL], 3)
      && $past(strap_sense.low[cms_pkg::STRAP_CAL], 3) |-> pin_cfg.dual_edge_sampling)
      else $error("Contradictory pad sense not resolved as floating.");

   AST_HELD_WHILE_FILLING: assert property (
      !sync_full |=> !serial_mode && serial_port == cms_pkg::SERIAL_IDLE
      && pin_cfg == cms_pkg::CFG_RESET)
      else $error("Outputs left their reset values before the synchroniser filled.");

endmodule // cms_strap_decode

`default_nettype wire

// *** bench/cms_strap_board.sv ***
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Board strap wiring
// ****************************************************************
// A floating pad reads as neither threshold, or as both when clash is set.
module cms_strap_board (
   input wire logic [11:0] levels,
   input wire logic clash,
   output var cms_pkg::cms_sense_t sense
);
   always_comb begin
      for (int i = 0; i < cms_pkg::STRAP_COUNT; i++) begin
         sense.high[i] = (levels[2*i +: 2] == cms_pkg::CMS_HIGH) ||
                         (levels[2*i +: 2] == cms_pkg::CMS_FLOAT && clash);
         sense.low[i] = (levels[2*i +: 2] == cms_pkg::CMS_LOW) ||
                        (levels[2*i +: 2] == cms_pkg::CMS_FLOAT && clash);
      end
   end
endmodule // cms_strap_board

`default_nettype wire

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   typedef struct packed {
      logic [11:0] s;
      logic m;
      cms_pkg::cms_cfg_t c;
      cms_pkg::cms_serial_t p;
   } cms_row_t;
   logic clk_sys;
   logic resetn;
   logic [11:0] levels;
   logic clash;
   cms_pkg::cms_sense_t strap_sense;
   logic serial_mode;
   cms_pkg::cms_cfg_t pin_cfg;
   cms_pkg::cms_serial_t serial_port;
   int fails;
   int comparisons;
   int cycles = 0;
   cms_row_t rows [9];

   cms_strap_board i_board (.levels(levels), .clash(clash), .sense(strap_sense));
   cms_strap_decode i_dut (.clk_sys(clk_sys), .resetn(resetn), .strap_sense(strap_sense),
      .serial_mode(serial_mode), .pin_cfg(pin_cfg), .serial_port(serial_port));

   // ****************************************************************
   // Clock and timeout
   // ****************************************************************
   initial begin
      clk_sys = 1'h0;
      forever #5 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         fails = fails + 1;
         stop_test();
      end
   end

   // ****************************************************************
   // Tasks
   // ****************************************************************
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic bad(input logic [5:0] got, input logic [5:0] exp);
      fails = fails + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
   endtask

   task automatic chk_mode(input logic exp);
      comparisons = comparisons + 1;
      if (serial_mode !== exp) bad({5'h0, serial_mode}, {5'h0, exp});
   endtask

   task automatic chk_cfg(input cms_pkg::cms_cfg_t exp);
      comparisons = comparisons + 1;
      if (pin_cfg !== exp) bad(pin_cfg, exp);
   endtask

   task automatic chk_port(input cms_pkg::cms_serial_t exp);
      comparisons = comparisons + 1;
      if (serial_port !== exp) bad({3'h0, serial_port}, {3'h0, exp});
   endtask

   task automatic stop_test();
      $display("comparisons=%0d fails=%0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   // Row levels are {range, cal, edge, swing, secondary, primary}, two bits each.
   initial begin
      fails = 0;
      comparisons = 0;
      resetn = 1'h0;
      clash = 1'h0;
      levels = 12'h045;
      rows[0] = {12'h045, 1'h0, 6'h38, 3'h1};
      rows[1] = {12'h515, 1'h0, 6'h02, 3'h1};
      rows[2] = {12'h7fd, 1'h0, 6'h05, 3'h1};
      rows[3] = {12'h447, 1'h0, 6'h18, 3'h1};
      rows[4] = {12'h11f, 1'h0, 6'h22, 3'h1};
      rows[5] = {12'hd17, 1'h1, 6'h22, 3'h5};
      rows[6] = {12'h04c, 1'h1, 6'h22, 3'h2};
      rows[7] = {12'h570, 1'h0, 6'h0a, 3'h1};
      rows[8] = {12'hff4, 1'h1, 6'h0a, 3'h0};
      step(3);
      resetn = 1'h1;
      for (int i = 0; i < 9; i++) begin
         levels = rows[i].s;
         step(4);
         chk_mode(rows[i].m);
         chk_cfg(rows[i].c);
         chk_port(rows[i].p);
      end
      // Change takes exactly three edges to reach the outputs.
      levels = 12'h045;
      step(2);
      chk_mode(1'h1);
      step(1);
      chk_mode(1'h0);
      chk_cfg(6'h38);
      // Floating pads that trip both thresholds still read floating.
      clash = 1'h1;
      levels = 12'hd17;
      step(4);
      chk_mode(1'h1);
      chk_port(3'h5);
      clash = 1'h0;
      // The host frames nine one-bit serial accesses with chip select low; the settings hold throughout.
      for (int a = 0; a < 9; a++) begin
         levels = {2'h1, 2'h0, 1'h0, a[0], 6'h14};
         step(3);
         chk_mode(1'h1);
         chk_port({1'h1, a[0], 1'h0});
         levels = {2'h1, 2'h1, 2'h0, 6'h04};
         step(3);
         chk_port(3'h1);
      end
      chk_cfg(6'h38);
      // Reset in mid-run forces reset values at once.
      resetn = 1'h0;
      #1;
      chk_mode(cms_pkg::RST_SERIAL_MODE);
      chk_cfg(cms_pkg::CFG_RESET);
      chk_port(cms_pkg::SERIAL_IDLE);
      levels = 12'h515;
      step(3);
      resetn = 1'h1;
      step(2);
      chk_mode(cms_pkg::RST_SERIAL_MODE);
      chk_port(cms_pkg::SERIAL_IDLE);
      step(1);
      chk_mode(1'h0);
      chk_cfg(6'h02);
      chk_port(cms_pkg::SERIAL_IDLE);
      stop_test();
   end
endmodule // tb_top

`default_nettype wire
